// ### rtl/irmap_pkg.sv
// Constants for the indexed remap window and interrupt definition block.
package irmap_pkg;
   // Configuration dword byte addresses of the two index and data pairs.
   localparam logic [7:0]  CFG_INTR_IDX    = 8'h78;
   localparam int          CFG_INTR_IDX_LN = 2;
   localparam logic [7:0]  CFG_INTR_DATA   = 8'h7C;
   localparam logic [7:0]  CFG_REMAP_IDX   = 8'hE4;
   localparam logic [7:0]  CFG_REMAP_DLO   = 8'hE8;
   localparam logic [7:0]  CFG_REMAP_DHI   = 8'hEC;
   // Remap entry indexes.
   localparam int          REMAP_ENTRIES   = 8;
   localparam logic [2:0]  RMP_NP_BASE     = 3'h0;
   localparam logic [2:0]  RMP_PRE_BASE    = 3'h1;
   localparam logic [2:0]  RMP_PRI_UPPER   = 3'h2;
   localparam logic [2:0]  RMP_RSVD_A      = 3'h3;
   localparam logic [2:0]  RMP_DMA_PRI     = 3'h4;
   localparam logic [2:0]  RMP_DMA_SBASE   = 3'h5;
   localparam logic [2:0]  RMP_DMA_SLIM    = 3'h6;
   localparam logic [2:0]  RMP_RSVD_B      = 3'h7;
   localparam logic [63:0] RMP_WMASK_ALL   = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] RMP_WMASK_DMA   = 64'hFFFF_FFFF_FFF0_00FF;
   localparam logic [63:0] RMP_RESET       = 64'h0000_0000_0000_0000;
   // DMA window control and address layout.
   localparam int          DMA_EN_BIT      = 0;
   localparam int          DMA_ISOC_BIT    = 2;
   localparam int          WIN_ADDR_LSB    = 20;
   // Read control 2 field positions.
   localparam int          RD2_WIDTH       = 16;
   localparam int          RD2_PFLEN_LSB   = 0;
   localparam int          RD2_PFCNT_LSB   = 4;
   localparam int          PF_W            = 3;
   // Interrupt definition registers.
   localparam int          NUM_SRC         = 10;
   localparam int          SRC_W           = 4;
   localparam logic [7:0]  INTDEF_BASE_IDX = 8'h10;
   localparam logic [7:0]  INTDEF_LAST_IDX = 8'h23;
   localparam int          EOI_PEND_BIT    = 63;
   localparam int          PASSPW_BIT      = 62;
   localparam int          REQUEST_EOI_ENABLE_BIT       = 5;
   localparam int          POL_BIT         = 1;
   localparam int          MASK_BIT        = 0;
   localparam logic [63:0] INTDEF_RESET    = 64'h4000_0000_F800_0001;
   localparam logic [63:0] INTDEF_WMASK    = 64'h00FF_FFFF_FFFF_FF7F;
endpackage : irmap_pkg

// ### rtl/irmap_pick.sv
// Fixed priority picker that offers one eligible interrupt source.
`timescale 1ns/1ps
module irmap_pick
   import irmap_pkg::*;
(
   input  wire logic               core_clk_in,
   input  wire logic               reset_in,
   input  wire logic [NUM_SRC-1:0] req_in,
   input  wire logic               take_in,
   output logic                    grant_valid_out,
   output logic [SRC_W-1:0]        grant_idx_out
);
   typedef struct packed {
      logic             valid;
      logic [SRC_W-1:0] idx;
   } irmap_pick_t;

   irmap_pick_t s_reg;
   irmap_pick_t s_next;

   // A grant is dropped for one cycle after it is taken, so the taken
   // source has raised the parent's message valid before the next choice.
   always_comb begin
      s_next = s_reg;
      s_next.valid = 1'b0;
      if (!take_in) begin
         for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req_in[i]) begin
               s_next.valid = 1'b1;
               s_next.idx   = SRC_W'(i);
            end
         end
      end
      if (reset_in) begin
         s_next = '0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      s_reg <= s_next;
   end

   assign grant_valid_out = s_reg.valid;
   assign grant_idx_out   = s_reg.idx;
endmodule : irmap_pick

// ### rtl/irmap_regs.sv
// Indexed remap window registers, DMA window check and interrupt sources.
`timescale 1ns/1ps
// Overview of operation
// [R1] Remap entries are reached by an index register and a data window.
// [R2] One DMA window: primary base, secondary base and secondary limit.
// [R3] Requests hitting the DMA window carry Isoc when the isoc bit is set.
// [R4] Isoc tagging changes only that bit; no separate channel buffering.
// [R5] DMA window hits take prefetch length and count from read control 2.
// [R6] Interrupt definitions are reached by their own index and data pair.
// [R7] Ten interrupt sources, each with a 64-bit definition register.
// [R8] Source n sits at index 16 plus twice n, two indexes each.
// [R9] Low word at the even index, high word at the odd index.
// [R10] Definitions drive interrupt messages only in the legacy mode.
// [R11] In the newer mode they read as stored, nonzero contents allowed.
// [R12] With EOI requested, pending bit sets on send, clears on EOI.
// [R13] Writing one clears the pending bit; it resets to zero.
// [R14] The pass-posted-write bit is read-only and reads one.
// [R15] Interrupt messages carry pass-posted-write set.
// [R16] Bits 31 to 24 are read-write and reset to F8h.
// [R17] Software never writes F9h or above into bits 31 to 24.
// [R18] Bit 7 is read-only zero.
// [R19] With EOI requested, no new message while the pending bit is set.
// [R20] A set mask bit stops messages; mask resets to one.
// [R21] Unmapped indexes read zero and ignore writes.
// [R22] Bits 55 to 32 and 23 to 8 are read-write, reset zero.
module irmap_regs
   import irmap_pkg::*;
(
   input  wire logic               core_clk_in,
   input  wire logic               reset_in,
   input  wire logic               cfg_wr_in,
   input  wire logic               cfg_rd_in,
   input  wire logic [7:0]         cfg_addr_in,
   input  wire logic [31:0]        cfg_wdata_in,
   input  wire logic [3:0]         cfg_be_in,
   output logic [31:0]             cfg_rdata_out,
   output logic                    cfg_rvalid_out,
   input  wire logic               req_valid_in,
   input  wire logic [63:0]        req_addr_in,
   input  wire logic [RD2_WIDTH-1:0] read_ctrl2_in,
   output logic                    req_valid_out,
   output logic [63:0]             req_addr_out,
   output logic                    req_dma_hit_out,
   output logic                    req_isoc_out,
   output logic [PF_W-1:0]         req_pf_len_out,
   output logic [PF_W-1:0]         req_pf_cnt_out,
   input  wire logic               newer_revision_mode_in,
   input  wire logic [NUM_SRC-1:0] int_src_in,
   output logic                    msg_valid_out,
   input  wire logic               msg_ready_in,
   output logic [SRC_W-1:0]        msg_src_out,
   output logic [63:0]             msg_info_out,
   output logic                    msg_passpw_out,
   input  wire logic               eoi_valid_in,
   input  wire logic [SRC_W-1:0]   eoi_src_in
);
   typedef struct packed {
      logic [7:0]                      remap_idx;
      logic [7:0]                      intr_idx;
      logic [REMAP_ENTRIES-1:0][63:0]  remap;
      logic [NUM_SRC-1:0][63:0]        idef;
      logic [NUM_SRC-1:0]              pend;
      logic [NUM_SRC-1:0]              act_q;
      logic                            msg_valid;
      logic [SRC_W-1:0]                msg_src;
      logic [63:0]                     msg_info;
      logic [31:0]                     rdata;
      logic                            rvalid;
      logic                            req_valid;
      logic [63:0]                     req_addr;
      logic                            req_hit;
      logic                            req_isoc;
      logic [PF_W-1:0]                 pf_len;
      logic [PF_W-1:0]                 pf_cnt;
   } irmap_state_t;

   irmap_state_t       s_reg;
   irmap_state_t       s_next;
   logic               pick_valid;
   logic [SRC_W-1:0]   pick_idx;
   logic               take;
   logic [NUM_SRC-1:0] elig;
   logic [NUM_SRC-1:0] act;
   logic               intr_ok;
   logic [7:0]         intr_off;
   logic [SRC_W-1:0]   intr_src;
   logic [63:0]        sbase;
   logic [63:0]        slimit;
   logic               hit;

   // Writes one byte-enabled word into a 64-bit entry, honouring the mask.
   function automatic logic [63:0] irmap_merge(input logic [63:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be,
                                               input logic        hi,
                                               input logic [63:0] wm);
      logic [31:0] lanes;
      logic [63:0] bm;
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      bm    = hi ? {lanes, 32'h0000_0000} : {32'h0000_0000, lanes};
      bm    = bm & wm;
      return (old & ~bm) | ({wd, wd} & bm);
   endfunction : irmap_merge

   // Writable bits of each remap entry.
   function automatic logic [63:0] irmap_remap_wm(input logic [7:0] idx);
      logic [63:0] wm;
      wm = RMP_WMASK_ALL;
      if (idx >= 8'(REMAP_ENTRIES)) begin
         wm = '0;
      end else begin
         case (idx[2:0])
            RMP_RSVD_A, RMP_RSVD_B: wm = '0;
            RMP_DMA_PRI, RMP_DMA_SBASE, RMP_DMA_SLIM: wm = RMP_WMASK_DMA;
            default: wm = RMP_WMASK_ALL;
         endcase
      end
      return wm;
   endfunction : irmap_remap_wm

   // Selected word of a remap entry; reserved entries read zero.
   function automatic logic [31:0] irmap_remap_rd(input irmap_state_t s,
                                                  input logic hi);
      logic [63:0] v;
      v = s.remap[s.remap_idx[2:0]] & irmap_remap_wm(s.remap_idx);
      return hi ? v[63:32] : v[31:0];
   endfunction : irmap_remap_rd

   irmap_pick u_pick (
      .core_clk_in     (core_clk_in),
      .reset_in        (reset_in),
      .req_in          (elig),
      .take_in         (take),
      .grant_valid_out (pick_valid),
      .grant_idx_out   (pick_idx)
   );

   always_comb begin
      intr_off = s_reg.intr_idx - INTDEF_BASE_IDX;
      intr_ok  = (s_reg.intr_idx >= INTDEF_BASE_IDX) &&
                 (s_reg.intr_idx <= INTDEF_LAST_IDX); // see [R21]
      intr_src = intr_off[SRC_W:1]; // see [R8]
      sbase  = {s_reg.remap[RMP_DMA_SBASE][63:WIN_ADDR_LSB],
                {WIN_ADDR_LSB{1'b0}}};
      slimit = {s_reg.remap[RMP_DMA_SLIM][63:WIN_ADDR_LSB],
                {WIN_ADDR_LSB{1'b1}}};
      hit = s_reg.remap[RMP_DMA_PRI][DMA_EN_BIT] &&
            (req_addr_in >= sbase) && (req_addr_in <= slimit); // see [R2]
      for (int i = 0; i < NUM_SRC; i++) begin
         act[i]  = int_src_in[i] ^ s_reg.idef[i][POL_BIT];
         elig[i] = s_reg.pend[i] && !s_reg.idef[i][MASK_BIT] && // see [R20]
                   !(s_reg.idef[i][REQUEST_EOI_ENABLE_BIT] &&
                     s_reg.idef[i][EOI_PEND_BIT]) && // see [R19]
                   !newer_revision_mode_in; // see [R10]
      end
      take = !s_reg.msg_valid && pick_valid && elig[pick_idx];
   end

   always_comb begin
      s_next = s_reg;

      // Reads answer one cycle later from the state before any write.
      s_next.rvalid = cfg_rd_in;
      s_next.rdata  = 32'h0000_0000;
      if (cfg_rd_in) begin
         case (cfg_addr_in)
            CFG_INTR_IDX:  s_next.rdata = {8'h00, s_reg.intr_idx, 16'h0000};
            CFG_INTR_DATA: begin
               if (intr_ok) begin // see [R6] [R11] [R21]
                  s_next.rdata = intr_off[0] ?
                     s_reg.idef[intr_src][63:32] :
                     s_reg.idef[intr_src][31:0]; // see [R9]
               end
            end
            CFG_REMAP_IDX: s_next.rdata = {24'h00_0000, s_reg.remap_idx};
            CFG_REMAP_DLO: s_next.rdata = irmap_remap_rd(s_reg, 1'b0);
            CFG_REMAP_DHI: s_next.rdata = irmap_remap_rd(s_reg, 1'b1);
            default:       s_next.rdata = 32'h0000_0000;
         endcase
      end

      if (cfg_wr_in) begin
         case (cfg_addr_in)
            CFG_INTR_IDX: begin
               if (cfg_be_in[CFG_INTR_IDX_LN]) begin
                  s_next.intr_idx = cfg_wdata_in[23:16]; // see [R6]
               end
            end
            CFG_INTR_DATA: begin
               if (intr_ok) begin
                  // Fixed bits keep their reset values through the mask.
                  s_next.idef[intr_src] = irmap_merge(
                     s_reg.idef[intr_src], cfg_wdata_in, cfg_be_in,
                     intr_off[0], INTDEF_WMASK); // see [R14] [R16] [R18] [R22]
                  if (intr_off[0] && cfg_be_in[3] && cfg_wdata_in[31]) begin
                     s_next.idef[intr_src][EOI_PEND_BIT] = 1'b0; // see [R13]
                  end
               end
            end
            CFG_REMAP_IDX: begin
               if (cfg_be_in[0]) begin
                  s_next.remap_idx = cfg_wdata_in[7:0]; // see [R1]
               end
            end
            CFG_REMAP_DLO, CFG_REMAP_DHI: begin
               s_next.remap[s_reg.remap_idx[2:0]] = irmap_merge(
                  s_reg.remap[s_reg.remap_idx[2:0]], cfg_wdata_in, cfg_be_in,
                  cfg_addr_in == CFG_REMAP_DHI,
                  irmap_remap_wm(s_reg.remap_idx)); // see [R1] [R21]
            end
            default: ;
         endcase
      end

      // Upstream requests: translate DMA window hits into the primary space.
      s_next.req_valid = req_valid_in;
      s_next.req_hit   = hit;
      s_next.req_addr  = hit ?
         req_addr_in - sbase + {s_reg.remap[RMP_DMA_PRI][63:WIN_ADDR_LSB],
                                {WIN_ADDR_LSB{1'b0}}} : req_addr_in;
      // Only the tag changes; routing stays on the base channels.
      s_next.req_isoc = hit &&
         s_reg.remap[RMP_DMA_PRI][DMA_ISOC_BIT]; // see [R3] [R4]
      s_next.pf_len = hit ?
         read_ctrl2_in[RD2_PFLEN_LSB +: PF_W] : '0; // see [R5]
      s_next.pf_cnt = hit ?
         read_ctrl2_in[RD2_PFCNT_LSB +: PF_W] : '0; // see [R5]

      // End of interrupt from the host clears the pending bit.
      if (eoi_valid_in && (eoi_src_in < SRC_W'(NUM_SRC))) begin
         s_next.idef[eoi_src_in][EOI_PEND_BIT] = 1'b0; // see [R12]
      end

      // Message accepted: drop the request and, if asked, await an EOI.
      if (s_reg.msg_valid && msg_ready_in) begin
         s_next.msg_valid = 1'b0;
         s_next.pend[s_reg.msg_src] = 1'b0;
         if (s_reg.idef[s_reg.msg_src][REQUEST_EOI_ENABLE_BIT]) begin
            // Applied after any clear so the hardware set wins.
            s_next.idef[s_reg.msg_src][EOI_PEND_BIT] = 1'b1; // see [R12]
         end
      end

      if (take) begin
         s_next.msg_valid = 1'b1;
         s_next.msg_src   = pick_idx;
         s_next.msg_info  = s_reg.idef[pick_idx];
         s_next.msg_info[PASSPW_BIT] = 1'b1; // see [R15]
      end

      // A new active edge is caught after the clear, so it is never lost.
      s_next.act_q = act;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (act[i] && !s_reg.act_q[i]) begin
            s_next.pend[i] = 1'b1;
         end
      end

      if (reset_in) begin
         s_next = '0;
         for (int i = 0; i < REMAP_ENTRIES; i++) begin
            s_next.remap[i] = RMP_RESET;
         end
         for (int i = 0; i < NUM_SRC; i++) begin
            s_next.idef[i] = INTDEF_RESET; // see [R7] [R13] [R16] [R20]
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      s_reg <= s_next;
   end

   assign cfg_rdata_out   = s_reg.rdata;
   assign cfg_rvalid_out  = s_reg.rvalid;
   assign req_valid_out   = s_reg.req_valid;
   assign req_addr_out    = s_reg.req_addr;
   assign req_dma_hit_out = s_reg.req_hit;
   assign req_isoc_out    = s_reg.req_isoc;
   assign req_pf_len_out  = s_reg.pf_len;
   assign req_pf_cnt_out  = s_reg.pf_cnt;
   assign msg_valid_out   = s_reg.msg_valid;
   assign msg_src_out     = s_reg.msg_src;
   assign msg_info_out    = s_reg.msg_info;
   assign msg_passpw_out  = s_reg.msg_info[PASSPW_BIT];
endmodule : irmap_regs

// ### verification/irmap_regs_properties.sv
// Concurrent checks on the ports of the remap and interrupt block.
`timescale 1ns/1ps
module irmap_regs_properties
   import irmap_pkg::*;
(
   input wire logic                 core_clk_in,
   input wire logic                 reset_in,
   input wire logic                 cfg_rd_in,
   input wire logic                 cfg_rvalid_out,
   input wire logic                 req_valid_in,
   input wire logic [63:0]          req_addr_in,
   input wire logic [RD2_WIDTH-1:0] read_ctrl2_in,
   input wire logic                 req_valid_out,
   input wire logic [63:0]          req_addr_out,
   input wire logic                 req_dma_hit_out,
   input wire logic                 req_isoc_out,
   input wire logic [PF_W-1:0]      req_pf_len_out,
   input wire logic [PF_W-1:0]      req_pf_cnt_out,
   input wire logic                 newer_revision_mode_in,
   input wire logic                 msg_valid_out,
   input wire logic                 msg_ready_in,
   input wire logic [SRC_W-1:0]     msg_src_out,
   input wire logic [63:0]          msg_info_out,
   input wire logic                 msg_passpw_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   a_read_answer: assert property (cfg_rd_in |=> cfg_rvalid_out)
      else $error("read strobe got no answer");
   a_req_passes: assert property (req_valid_in |=> req_valid_out &&
      (req_dma_hit_out || req_addr_out == $past(req_addr_in)))
      else $error("request lost or missed address altered");
   a_isoc_on_hit: assert property (req_isoc_out |-> req_dma_hit_out)
      else $error("isoc tag outside the window");
   a_pf_on_miss: assert property (!req_dma_hit_out |->
      req_pf_len_out == 3'h0 && req_pf_cnt_out == 3'h0)
      else $error("prefetch fields on a miss");
   a_pf_from_ctrl: assert property (req_dma_hit_out |->
      {req_pf_cnt_out, 1'b0, req_pf_len_out} ==
      ($past(read_ctrl2_in[6:0]) & 7'h77))
      else $error("prefetch fields differ from read control");
   a_passpw_set: assert property (msg_valid_out |-> msg_passpw_out)
      else $error("message without pass posted write");
   a_msg_holds: assert property (msg_valid_out && !msg_ready_in |=>
      msg_valid_out && $stable(msg_src_out) && $stable(msg_info_out))
      else $error("message changed before acceptance");
   a_one_accept: assert property (msg_valid_out && msg_ready_in
      |=> !msg_valid_out)
      else $error("message repeated after acceptance");
   a_newer_quiet: assert property (newer_revision_mode_in [*4]
      |=> !$rose(msg_valid_out))
      else $error("message sent in newer mode");
   c_isoc_hit: cover property (req_dma_hit_out && req_isoc_out);
   c_msg_stall: cover property (msg_valid_out && !msg_ready_in);
   c_msg_take: cover property (msg_valid_out && msg_ready_in);
endmodule : irmap_regs_properties

bind irmap_regs irmap_regs_properties i_irmap_regs_properties (
   .core_clk_in, .reset_in, .cfg_rd_in, .cfg_rvalid_out, .req_valid_in,
   .req_addr_in, .read_ctrl2_in, .req_valid_out, .req_addr_out,
   .req_dma_hit_out, .req_isoc_out, .req_pf_len_out, .req_pf_cnt_out,
   .newer_revision_mode_in, .msg_valid_out, .msg_ready_in, .msg_src_out,
   .msg_info_out, .msg_passpw_out);

// ### verification/irmap_host_model.sv
// Host bridge model that takes interrupt messages and returns EOIs.
`timescale 1ns/1ps
module irmap_host_model
   import irmap_pkg::*;
(
   input  wire logic             core_clk_in,
   input  wire logic             reset_in,
   input  wire logic             msg_valid_in,
   input  wire logic [SRC_W-1:0] msg_src_in,
   input  wire logic [3:0]       stall_in,
   input  wire logic             eoi_auto_in,
   output logic                  msg_ready_out,
   output logic                  eoi_valid_out,
   output logic [SRC_W-1:0]      eoi_src_out,
   output logic [7:0]            got_cnt_out,
   output logic [SRC_W-1:0]      got_src_out
);
   logic [3:0] wait_cnt;
   // The EOI source toggles while idle so a design that ignores the
   // strobe cannot lean on a stale value.
   always_ff @(posedge core_clk_in) begin
      eoi_valid_out <= 1'b0;
      eoi_src_out   <= ~eoi_src_out;
      if (reset_in) begin
         wait_cnt      <= 4'h0;
         msg_ready_out <= 1'b0;
         got_cnt_out   <= 8'h00;
         got_src_out   <= 4'h0;
         eoi_src_out   <= 4'h0;
      end else if (msg_valid_in && msg_ready_out) begin
         msg_ready_out <= 1'b0;
         wait_cnt      <= 4'h0;
         got_cnt_out   <= got_cnt_out + 8'h01;
         got_src_out   <= msg_src_in;
         eoi_valid_out <= eoi_auto_in;
         eoi_src_out   <= msg_src_in;
      end else if (msg_valid_in) begin
         wait_cnt      <= wait_cnt + 4'h1;
         msg_ready_out <= (wait_cnt >= stall_in);
      end
   end
endmodule : irmap_host_model

// ### verification/tb_top.sv
// Self-checking bench for the remap window and interrupt definitions.
`timescale 1ns/1ps
module tb_top;
   import irmap_pkg::*;
   logic core_clk_in = 1'b0, reset_in = 1'b1, cfg_wr_in = 1'b0;
   logic cfg_rd_in = 1'b0, req_valid_in = 1'b0, eoi_auto = 1'b0;
   logic newer_revision_mode_in = 1'b0, msg_ready_in, eoi_valid_in;
   logic cfg_rvalid_out, req_valid_out, req_dma_hit_out, req_isoc_out;
   logic msg_valid_out, msg_passpw_out;
   logic [7:0]           cfg_addr_in = 8'h00, got_cnt;
   logic [31:0]          cfg_wdata_in = 32'h0000_0000, cfg_rdata_out;
   logic [3:0]           cfg_be_in = 4'h0, stall = 4'h0;
   logic [63:0]          req_addr_in = 64'h0, req_addr_out, msg_info_out;
   logic [RD2_WIDTH-1:0] read_ctrl2_in = 16'h0053;
   logic [NUM_SRC-1:0]   int_src_in = 10'h000;
   logic [SRC_W-1:0]     msg_src_out, eoi_src_in, got_src;
   logic [PF_W-1:0]      req_pf_len_out, req_pf_cnt_out;
   int                   failures = 0, checked = 0;
   irmap_regs i_irmap_regs (.core_clk_in, .reset_in, .cfg_wr_in, .cfg_rd_in,
      .cfg_addr_in, .cfg_wdata_in, .cfg_be_in, .cfg_rdata_out,
      .cfg_rvalid_out, .req_valid_in, .req_addr_in, .read_ctrl2_in,
      .req_valid_out, .req_addr_out, .req_dma_hit_out, .req_isoc_out,
      .req_pf_len_out, .req_pf_cnt_out, .newer_revision_mode_in,
      .int_src_in, .msg_valid_out, .msg_ready_in, .msg_src_out,
      .msg_info_out, .msg_passpw_out, .eoi_valid_in, .eoi_src_in);
   irmap_host_model i_irmap_host_model (.core_clk_in, .reset_in,
      .msg_valid_in(msg_valid_out), .msg_src_in(msg_src_out),
      .stall_in(stall), .eoi_auto_in(eoi_auto),
      .msg_ready_out(msg_ready_in), .eoi_valid_out(eoi_valid_in),
      .eoi_src_out(eoi_src_in), .got_cnt_out(got_cnt),
      .got_src_out(got_src));
   initial forever #2.5 core_clk_in = ~core_clk_in;
   task automatic finish_test;
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] be);
      @(posedge core_clk_in);
      cfg_wr_in    <= 1'b1;
      cfg_addr_in  <= a;
      cfg_wdata_in <= d;
      cfg_be_in    <= be;
      @(posedge core_clk_in);
      cfg_wr_in    <= 1'b0;
   endtask : cfg_wr
   task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_in);
      cfg_rd_in   <= 1'b1;
      cfg_addr_in <= a;
      @(posedge core_clk_in);
      cfg_rd_in   <= 1'b0;
      #1;
      chk(cfg_rvalid_out, 64'h1);
      chk(cfg_rdata_out, exp);
   endtask : cfg_rd
   // The interrupt index lives in byte lane 2 of its dword.
   task automatic def_wr(input logic [7:0] i, input logic [31:0] d,
                         input logic [3:0] be);
      cfg_wr(CFG_INTR_IDX, {8'h00, i, 16'h0000}, 4'h4);
      cfg_wr(CFG_INTR_DATA, d, be);
   endtask : def_wr
   task automatic def_rd(input logic [7:0] i, input logic [31:0] exp);
      cfg_wr(CFG_INTR_IDX, {8'h00, i, 16'h0000}, 4'h4);
      cfg_rd(CFG_INTR_DATA, exp);
   endtask : def_rd
   task automatic rmp_wr(input logic [7:0] i, input logic [31:0] d);
      cfg_wr(CFG_REMAP_IDX, {24'h00_0000, i}, 4'h1);
      cfg_wr(CFG_REMAP_DLO, d, 4'hF);
   endtask : rmp_wr
   task automatic req(input logic [63:0] a, input logic [63:0] xa,
                      input logic [7:0] flags);
      @(posedge core_clk_in);
      req_valid_in <= 1'b1;
      req_addr_in  <= a;
      @(posedge core_clk_in);
      req_valid_in <= 1'b0;
      #1;
      chk(req_addr_out, xa);
      chk({req_valid_out, req_dma_hit_out, req_isoc_out, req_pf_cnt_out,
           req_pf_len_out}, {1'b1, flags});
   endtask : req
   task automatic pulse(input int n);
      @(posedge core_clk_in);
      int_src_in[n] <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      int_src_in[n] <= 1'b0;
   endtask : pulse
   task automatic wait_msg(input logic [7:0] n);
      for (int i = 0; i < 60 && got_cnt !== n; i++)
         @(posedge core_clk_in);
      chk(got_cnt, n);
   endtask : wait_msg
   task automatic quiet(input logic [7:0] n);
      repeat (20) @(posedge core_clk_in);
      chk(got_cnt, n);
   endtask : quiet
   task automatic t_reset_vals;
      def_rd(8'h10, 32'hF800_0001);
      def_rd(8'h23, 32'h4000_0000);
      def_wr(8'h23, 32'h0000_0000, 4'hF);
      def_rd(8'h23, 32'h4000_0000);
      req(64'h10, 64'h10, 8'h00);
   endtask : t_reset_vals
   task automatic t_def_fields;
      def_wr(8'h16, 32'hF8AB_CDFF, 4'hF);
      def_rd(8'h16, 32'hF8AB_CD7F);
      def_wr(8'h17, 32'hFFFF_FFFF, 4'hF);
      def_rd(8'h17, 32'h40FF_FFFF);
      def_wr(8'h24, 32'hFFFF_FFFF, 4'hF);
      def_rd(8'h24, 32'h0000_0000);
      def_rd(8'h0F, 32'h0000_0000);
      rmp_wr(8'h03, 32'hFFFF_FFFF);
      cfg_rd(CFG_REMAP_DLO, 32'h0000_0000);
      cfg_rd(8'h80, 32'h0000_0000);
   endtask : t_def_fields
   task automatic t_dma_window;
      rmp_wr(8'h04, 32'h3000_FF05);
      cfg_rd(CFG_REMAP_DLO, 32'h3000_0005);
      rmp_wr(8'h05, 32'h1000_0000);
      rmp_wr(8'h06, 32'h1000_0000);
      req(64'h1000_1234, 64'h3000_1234, 8'hEB);
      req(64'h100F_FFFF, 64'h300F_FFFF, 8'hEB);
      req(64'h1010_0000, 64'h1010_0000, 8'h00);
      req(64'h0FFF_FFFF, 64'h0FFF_FFFF, 8'h00);
      rmp_wr(8'h04, 32'h3000_0001);
      read_ctrl2_in <= 16'h0072;
      req(64'h1000_0010, 64'h3000_0010, 8'hBA);
   endtask : t_dma_window
   task automatic t_intr_eoi;
      def_wr(8'h14, 32'hF800_0020, 4'hF);
      pulse(2);
      wait_msg(8'h01);
      chk(got_src, 64'h2);
      chk(msg_info_out, 64'h4000_0000_F800_0020);
      def_rd(8'h15, 32'hC000_0000);
      pulse(2);
      quiet(8'h01);
      def_wr(8'h15, 32'h8000_0000, 4'h8);
      wait_msg(8'h02);
      eoi_auto <= 1'b1;
      stall    <= 4'h3;
      def_wr(8'h15, 32'h8000_0000, 4'h8);
      pulse(2);
      wait_msg(8'h03);
      def_rd(8'h15, 32'h4000_0000);
   endtask : t_intr_eoi
   task automatic t_mask_mode;
      pulse(4);
      quiet(8'h03);
      newer_revision_mode_in <= 1'b1;
      def_wr(8'h1A, 32'hF800_0000, 4'hF);
      pulse(5);
      quiet(8'h03);
      def_rd(8'h1A, 32'hF800_0000);
      newer_revision_mode_in <= 1'b0;
      wait_msg(8'h04);
      chk(got_src, 64'h5);
      chk(msg_info_out, 64'h4000_0000_F800_0000);
   endtask : t_mask_mode
   // The whole run needs well under a thousand cycles.
   initial begin
      #100000;
      failures++;
      finish_test;
   end
   initial begin
      repeat (3) @(posedge core_clk_in);
      reset_in <= 1'b0;
      t_reset_vals;
      t_def_fields;
      t_dma_window;
      t_intr_eoi;
      t_mask_mode;
      finish_test;
   end
endmodule : tb_top
